// ===== design/rcs_pkg.sv
// Package with register map, field positions, encodings and timing constants.
`default_nettype none
package rcs_pkg;
    // --------------------------------------------------------------------
    // Register map (byte addresses on the APB bus).
    // --------------------------------------------------------------------
    localparam logic [11:0] RCS_ADDR_CLK_MODE = 12'h000; // Clock-mode register.
    localparam logic [11:0] RCS_ADDR_TRIM     = 12'h004; // Fast oscillator trim.
    localparam logic [11:0] RCS_ADDR_STATUS   = 12'h008; // Boot and clock status.
    localparam logic [11:0] RCS_ADDR_BOOT_CFG = 12'h00c; // Boot trim directive setup.
    // --------------------------------------------------------------------
    // Clock-mode fields.
    // --------------------------------------------------------------------
    localparam int RCS_BIT_FAST_EN = 4; // Fast oscillator enable.
    localparam int RCS_BIT_SLOW_EN = 2; // Slow oscillator enable.
    localparam int RCS_BIT_SEL_LO  = 3; // Low source/divider select bit.
    localparam int RCS_SEL_HI_TOP  = 7; // Top of the high select field.
    localparam int RCS_SEL_HI_BOT  = 5; // Bottom of the high select field.
    localparam logic [7:0] RCS_CLK_MODE_RESET = 8'hf4; // Slow clock, fast kept on.
    localparam logic [7:0] RCS_CLK_MODE_BOOT_RST = 8'he4; // Slow core, fast off.
    // Select codes {bits 7:5, bit 3}.
    localparam logic [3:0] RCS_SEL_DIV2  = 4'h2; // Encoding 34h.
    localparam logic [3:0] RCS_SEL_DIV4  = 4'h0; // Encoding 14h.
    localparam logic [3:0] RCS_SEL_DIV8  = 4'h3; // Encoding 3Ch.
    localparam logic [3:0] RCS_SEL_DIV16 = 4'h1; // Encoding 1Ch.
    localparam logic [3:0] RCS_SEL_DIV32 = 4'h7; // Encoding 7Ch.
    localparam logic [3:0] RCS_SEL_SLOW  = 4'he; // Encodings E4h and F4h.
    // --------------------------------------------------------------------
    // Trim and timing.
    // --------------------------------------------------------------------
    localparam logic [7:0]  RCS_TRIM_RESET      = 8'h80; // Mid-scale, uncalibrated.
    localparam int          RCS_TRIM_MHZ_MIN    = 14;    // Lowest trim target.
    localparam int          RCS_TRIM_MHZ_MAX    = 18;    // Highest trim target.
    localparam int          RCS_TRIM_MHZ_NOM    = 16;    // Usual trim target.
    localparam int          RCS_BOOT_SLOW_CYC   = 3000;  // Boot delay in slow cycles.
    localparam int          RCS_CLK_MHZ         = 125;   // System clock rate.
    localparam int          RCS_SLOW_KHZ        = 40;    // Slow oscillator model rate.
    localparam int          RCS_SLOW_DIV        = (RCS_CLK_MHZ * 1000) / RCS_SLOW_KHZ;
    localparam int          RCS_STATUS_BOOTED   = 0;     // Status: program may run.
    localparam int          RCS_STATUS_FAST_SEL = 1;     // Status: core on fast clock.
    localparam int          RCS_STATUS_WDT_EN   = 2;     // Status: watchdog enabled.
    localparam int          RCS_STATUS_AUX_IN   = 3;     // Status: aux pin is input.
endpackage
`default_nettype wire

// ===== design/rcs_divider.sv
// Enable-pulse divider used for the oscillator model rates.
`default_nettype none
module rcs_divider
    import rcs_pkg::*;
#(
    parameter int WIDTH = 16 // Counter width.
)
(
    input  wire logic             clk,      // System clock.
    input  wire logic             reset_n,  // Synchronous reset, active low.
    input  wire logic             run,      // Divider runs while high.
    input  wire logic [WIDTH-1:0] period,   // Pulse spacing minus one.
    output var  logic             tick      // One-cycle enable pulse.
);
    // --------------------------------------------------------------------
    // Counter.
    // --------------------------------------------------------------------
    logic [WIDTH-1:0] count;      // Cycles since the last pulse.
    logic [WIDTH-1:0] next_count; // Next counter value.
    logic             next_tick;  // Next pulse value.

    // A stopped divider restarts from zero so its first pulse is a full period late.
    always_comb
    begin
        next_count = count;
        next_tick  = 1'b0;
        if (!run)
        begin
            next_count = '0;
        end
        else if (count >= period)
        begin
            next_count = '0;
            next_tick  = 1'b1;
        end
        else
        begin
            next_count = count + 1'b1;
        end
    end

    // Registers only.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            count <= '0;
            tick  <= 1'b0;
        end
        else
        begin
            count <= next_count;
            tick  <= next_tick;
        end
    end
endmodule
`default_nettype wire

// ===== design/rcs_clock_ctrl.sv
// Core clock source selection, oscillator enables, trim and boot delay.
//
// What this block does
// - Bit 4 enables fast, bit 2 slow oscillator.
// - After a boot without trim directive only slow oscillator runs.
// - Hold execution 3000 slow cycles after reset.
// - Write 34h: fast divided by two.
// - Write 14h: fast divided by four.
// - 3Ch, 1Ch, 7Ch: divide by 8/16/32.
// - Write E4h: slow clock, fast off.
// - Write F4h: slow clock, fast kept on.
// - Writes accepted anytime, take effect immediately.
// - Trim register for fast oscillator, nominal 16MHz.
// - Trim 14 to 18 MHz; dividers 2..32.
// - Trim boot: watchdog off, slow per bit 2 of directive mode, pin input.
// - No trim boot: reset clock mode, watchdog on.
//
// The register addresses and the APB interface to the registers were chosen for this implementation.

`default_nettype none
module rcs_clock_ctrl
    import rcs_pkg::*;
#(
    parameter int FAST_DIV = 8,            // System cycles per fast oscillator tick.
    parameter int SLOW_DIV = RCS_SLOW_DIV, // System cycles per slow oscillator tick.
    parameter int BOOT_CYC = RCS_BOOT_SLOW_CYC // Boot delay in slow ticks.
)
(
    input  wire logic        clk,            // System clock, 125 MHz.
    input  wire logic        reset_n,        // Synchronous reset, active low.
    input  wire logic        psel,           // APB select.
    input  wire logic        penable,        // APB enable.
    input  wire logic        pwrite,         // APB direction.
    input  wire logic [11:0] paddr,          // APB byte address.
    input  wire logic [31:0] pwdata,         // APB write data.
    input  wire logic [3:0]  pstrb,          // APB byte strobes.
    output var  logic [31:0] prdata,         // APB read data.
    output var  logic        pready,         // APB ready.
    output var  logic        pslverr,        // APB error.
    output var  logic        fast_rc_osc_en, // Fast oscillator running.
    output var  logic        slow_rc_osc_en, // Slow oscillator running.
    output var  logic        core_clock_en,  // One-cycle core clock enable.
    output var  logic        core_run,       // Program may execute.
    output var  logic        wdt_enable,     // Watchdog enabled after boot.
    output var  logic        aux_reset_port_pin_in // Aux pin forced to input.
);

    // --------------------------------------------------------------------
    // Helpers.
    // --------------------------------------------------------------------
    // Decodes the core divider (period minus one, in fast ticks) from a mode.
    // Slow-source codes return zero; the caller never uses the value then.
    function automatic logic [4:0] fast_period(input logic [7:0] mode);
        logic [3:0] sel;
        sel = {mode[RCS_SEL_HI_TOP:RCS_SEL_HI_BOT], mode[RCS_BIT_SEL_LO]};
        unique case (sel)
            RCS_SEL_DIV2:  fast_period = 5'd1;
            RCS_SEL_DIV4:  fast_period = 5'd3;
            RCS_SEL_DIV8:  fast_period = 5'd7;
            RCS_SEL_DIV16: fast_period = 5'd15;
            RCS_SEL_DIV32: fast_period = 5'd31;
            default:       fast_period = 5'd0;
        endcase
    endfunction

    // True when the mode selects the fast oscillator as core source.
    function automatic logic is_fast_sel(input logic [7:0] mode);
        logic [3:0] sel;
        sel = {mode[RCS_SEL_HI_TOP:RCS_SEL_HI_BOT], mode[RCS_BIT_SEL_LO]};
        is_fast_sel = (sel == RCS_SEL_DIV2) || (sel == RCS_SEL_DIV4) ||
                      (sel == RCS_SEL_DIV8) || (sel == RCS_SEL_DIV16) ||
                      (sel == RCS_SEL_DIV32);
    endfunction

    // --------------------------------------------------------------------
    // State.
    // --------------------------------------------------------------------
    typedef enum {ST_BOOT, ST_APPLY, ST_RUN} rcs_boot_e;

    // Software-visible register state.
    logic [7:0]  clk_mode;       // Clock-mode register.
    logic [7:0]  next_clk_mode;  // Next clock-mode value.
    logic [7:0]  trim;           // Fast oscillator trim code.
    logic [7:0]  next_trim;      // Next trim code.
    logic [7:0]  boot_mode;      // Mode the boot trim directive installs.
    logic [7:0]  next_boot_mode; // Next boot mode value.
    logic        boot_trim;      // Boot trim directive in use.
    logic        next_boot_trim; // Next directive flag.

    // Boot sequencer and core divider state.
    rcs_boot_e   state;          // Boot sequencer state.
    rcs_boot_e   next_state;     // Next sequencer state.
    logic [11:0] boot_cnt;       // Slow ticks counted during boot.
    logic [11:0] next_boot_cnt;  // Next boot count.
    logic [4:0]  core_cnt;       // Fast ticks since last core pulse.
    logic [4:0]  next_core_cnt;  // Next core count.

    // Next values of the output flops.
    logic        next_core_en;   // Next core enable pulse.
    logic        next_wdt;       // Next watchdog enable.
    logic        next_aux_in;    // Next aux pin input force.
    logic [31:0] next_prdata;    // Next read data.
    logic        next_pready;    // Next ready.
    logic        next_pslverr;   // Next error.

    // Oscillator ticks and bus decode.
    logic        fast_tick;      // Fast oscillator model tick.
    logic        slow_tick;      // Slow oscillator model tick.
    logic        acc;            // Access phase of a transfer.
    logic        hit;            // Address maps to a register.

    // --------------------------------------------------------------------
    // Oscillator models.
    // --------------------------------------------------------------------
    // Each oscillator only ticks while its enable bit is set.
    // A restarted oscillator gives its first tick a full period late.
    rcs_divider #(.WIDTH(16)) u_fast
    (
        .clk     (clk),
        .reset_n (reset_n),
        .run     (clk_mode[RCS_BIT_FAST_EN]),
        .period  (16'(FAST_DIV - 1)),
        .tick    (fast_tick)
    );

    rcs_divider #(.WIDTH(16)) u_slow
    (
        .clk     (clk),
        .reset_n (reset_n),
        .run     (clk_mode[RCS_BIT_SLOW_EN]),
        .period  (16'(SLOW_DIV - 1)),
        .tick    (slow_tick)
    );

    // --------------------------------------------------------------------
    // APB slave and register file.
    // --------------------------------------------------------------------
    // One wait state: pready rises one cycle after the access phase starts.
    // Gating with pready keeps one access phase from being taken twice.
    assign acc = psel && penable && !pready;
    assign hit = (paddr == RCS_ADDR_CLK_MODE) || (paddr == RCS_ADDR_TRIM) ||
                 (paddr == RCS_ADDR_STATUS) || (paddr == RCS_ADDR_BOOT_CFG);

    // Register writes, read data and the bus answer of one access phase.
    // The boot directive comes last, so it wins over a write in the same cycle.
    always_comb
    begin
        next_clk_mode  = clk_mode;
        next_trim      = trim;
        next_boot_mode = boot_mode;
        next_boot_trim = boot_trim;
        next_prdata    = prdata;
        next_pready    = acc;
        next_pslverr   = acc && !hit;
        if (acc && pwrite && pstrb[0])
        begin
            // The mode is stored as written, so a switch lands the next cycle.
            // Software must not switch and stop the old source in one write.
            unique case (paddr)
                RCS_ADDR_CLK_MODE: next_clk_mode = pwdata[7:0];
                RCS_ADDR_TRIM:     next_trim     = pwdata[7:0];
                RCS_ADDR_BOOT_CFG:
                begin
                    next_boot_mode = pwdata[7:0];
                    next_boot_trim = pwdata[8] && pstrb[1];
                end
                default:           next_trim     = trim;
            endcase
        end
        if (acc && !pwrite)
        begin
            // Unmapped reads return zero together with pslverr.
            unique case (paddr)
                RCS_ADDR_CLK_MODE: next_prdata = {24'h000000, clk_mode};
                RCS_ADDR_TRIM:     next_prdata = {24'h000000, trim};
                RCS_ADDR_STATUS:   next_prdata = {28'h0000000, aux_reset_port_pin_in,
                                                  wdt_enable, is_fast_sel(clk_mode),
                                                  core_run};
                RCS_ADDR_BOOT_CFG: next_prdata = {23'h000000, boot_trim, boot_mode};
                default:           next_prdata = 32'h00000000;
            endcase
        end
        // The boot sequencer installs the directive's mode when boot ends.
        if (state == ST_APPLY && boot_trim)
        begin
            next_clk_mode = boot_mode;
        end
    end

    // --------------------------------------------------------------------
    // Boot sequencer and core clock enable.
    // --------------------------------------------------------------------
    // Boot only counts slow ticks; the fast oscillator stays off until written.
    // A reset in mid-run restarts the whole boot delay.
    always_comb
    begin
        next_state    = state;
        next_boot_cnt = boot_cnt;
        next_wdt      = wdt_enable;
        next_aux_in   = aux_reset_port_pin_in;
        unique case (state)
            ST_BOOT:
            begin
                if (slow_tick)
                begin
                    next_boot_cnt = boot_cnt + 12'h001;
                    if (boot_cnt == 12'(BOOT_CYC - 1))
                    begin
                        next_state = ST_APPLY;
                    end
                end
            end
            ST_APPLY:
            begin
                next_state  = ST_RUN;
                next_wdt    = !boot_trim;
                next_aux_in = boot_trim;
            end
            ST_RUN:
            begin
                // Only reset leaves the run state.
                next_state = ST_RUN;
            end
        endcase

        // The core pulse follows the current mode at once, with no resync delay.
        // A switch in mid-count may shorten the first core period, but only
        // whole enable pulses ever leave the block.
        next_core_cnt = core_cnt;
        next_core_en  = 1'b0;
        if (state == ST_RUN)
        begin
            if (is_fast_sel(clk_mode))
            begin
                if (fast_tick)
                begin
                    if (core_cnt >= fast_period(clk_mode))
                    begin
                        next_core_cnt = 5'd0;
                        next_core_en  = 1'b1;
                    end
                    else
                    begin
                        next_core_cnt = core_cnt + 5'd1;
                    end
                end
            end
            else
            begin
                next_core_cnt = 5'd0;
                next_core_en  = slow_tick;
            end
        end
    end

    // Registers only. The enables follow the mode register at the same edge
    // that stores a write, together with pready.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            // Reset gives the no-directive state: slow core, fast off.
            clk_mode              <= RCS_CLK_MODE_BOOT_RST;
            trim                  <= RCS_TRIM_RESET;
            boot_mode             <= RCS_CLK_MODE_BOOT_RST;
            boot_trim             <= 1'b0;
            state                 <= ST_BOOT;
            boot_cnt              <= 12'h000;
            core_cnt              <= 5'd0;
            core_clock_en         <= 1'b0;
            core_run              <= 1'b0;
            wdt_enable            <= 1'b1;
            aux_reset_port_pin_in <= 1'b0;
            prdata                <= 32'h00000000;
            pready                <= 1'b0;
            pslverr               <= 1'b0;
            fast_rc_osc_en        <= 1'b0;
            slow_rc_osc_en        <= 1'b1;
        end
        else
        begin
            clk_mode              <= next_clk_mode;
            trim                  <= next_trim;
            boot_mode             <= next_boot_mode;
            boot_trim             <= next_boot_trim;
            state                 <= next_state;
            boot_cnt              <= next_boot_cnt;
            core_cnt              <= next_core_cnt;
            core_clock_en         <= next_core_en;
            core_run              <= (next_state == ST_RUN);
            wdt_enable            <= next_wdt;
            aux_reset_port_pin_in <= next_aux_in;
            prdata                <= next_prdata;
            pready                <= next_pready;
            pslverr               <= next_pslverr;
            fast_rc_osc_en        <= next_clk_mode[RCS_BIT_FAST_EN];
            slow_rc_osc_en        <= next_clk_mode[RCS_BIT_SLOW_EN];
        end
    end
endmodule
`default_nettype wire

// ===== sim/rcs_clock_ctrl_asserts.sv
// Concurrent checks on the ports of the clock-control block.
`default_nettype none
module rcs_ctrl_chk
    import rcs_pkg::*;
#(
    parameter int SLOW_DIV = RCS_SLOW_DIV,     // System cycles per slow tick.
    parameter int BOOT_CYC = RCS_BOOT_SLOW_CYC // Boot delay in slow ticks.
)
(
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        fast_rc_osc_en,
    input wire logic        slow_rc_osc_en,
    input wire logic        core_clock_en,
    input wire logic        core_run,
    input wire logic        wdt_enable,
    input wire logic        aux_reset_port_pin_in
);
    localparam int HOLD = BOOT_CYC * SLOW_DIV; // Cycles with the program held.
    localparam int LIM  = HOLD + 12;           // Latest cycle for the start.
    logic [31:0] boot_cnt;      // Cycles since reset release.
    logic [31:0] next_boot_cnt; // Next count.
    // ------------------------------------------------------------------
    // Boot cycle counter
    // ------------------------------------------------------------------
    // It saturates, so a long run never wraps back into the hold window.
    always_comb
    begin
        next_boot_cnt = boot_cnt;
        if (boot_cnt < LIM[31:0])
        begin
            next_boot_cnt = boot_cnt + 32'h00000001;
        end
    end
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            boot_cnt <= 32'h00000000;
        else
            boot_cnt <= next_boot_cnt;
    end
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // An access phase still waiting for its answer.
    sequence s_access;
        psel && penable && !pready;
    endsequence
    // A write of the clock-mode register with the low lane enabled.
    sequence s_mode_wr;
        psel && penable && !pready && pwrite && (paddr == RCS_ADDR_CLK_MODE) && pstrb[0];
    endsequence
    a_ready_follows: assert property (s_access |=> pready)
        else $error("pready missing after access phase");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_fast_enable: assert property (s_mode_wr |=> fast_rc_osc_en == $past(pwdata[4]))
        else $error("fast oscillator enable not bit 4");
    a_slow_enable: assert property (s_mode_wr |=> slow_rc_osc_en == $past(pwdata[2]))
        else $error("slow oscillator enable not bit 2");
    a_unmapped_err: assert property (s_access ##0 (paddr > RCS_ADDR_BOOT_CFG) |=> pslverr)
        else $error("unmapped access without error");
    a_trim_mapped: assert property (s_access ##0 (paddr == RCS_ADDR_TRIM) |=> !pslverr)
        else $error("trim register access refused");
    a_boot_hold: assert property (boot_cnt < HOLD |-> !core_run)
        else $error("program started before boot delay");
    a_boot_done: assert property (boot_cnt == LIM |-> core_run)
        else $error("program not started after boot delay");
    a_run_sticky: assert property (core_run |=> core_run)
        else $error("program run dropped without reset");
    a_wdt_steady: assert property (core_run && $past(core_run) |-> $stable(wdt_enable))
        else $error("watchdog enable changed after boot");
endmodule
bind rcs_clock_ctrl rcs_ctrl_chk #(.SLOW_DIV(SLOW_DIV), .BOOT_CYC(BOOT_CYC)) rcs_ctrl_chk_inst (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fast_rc_osc_en(fast_rc_osc_en), .slow_rc_osc_en(slow_rc_osc_en),
    .core_clock_en(core_clock_en), .core_run(core_run), .wdt_enable(wdt_enable),
    .aux_reset_port_pin_in(aux_reset_port_pin_in));
`default_nettype wire

// ===== sim/rcs_clock_ctrl_bench.sv
// Self-checking bench for the clock-control block over APB.
`default_nettype none
module rcs_clock_ctrl_bench
    import rcs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SDIV = 4; // Shortened slow tick spacing.
    localparam int BOOT = 5; // Shortened boot delay in slow ticks.
    localparam int FDIV = 8; // Fast tick spacing.
    logic        clk, reset_n, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic        fast_en, slow_en, core_en, core_run, wdt_en, aux_in, err;
    int          n_fail, check_count, cyc, n;
    logic [7:0]  codes [8] = '{8'hf4, 8'h34, 8'h14, 8'h3c, 8'h1c, 8'h7c, 8'hf4, 8'he4};
    int          gaps [8] = '{SDIV, FDIV*2, FDIV*4, FDIV*8, FDIV*16, FDIV*32, SDIV, SDIV};
    rcs_clock_ctrl #(.FAST_DIV(FDIV), .SLOW_DIV(SDIV), .BOOT_CYC(BOOT)) rcs_clock_ctrl_inst (
        .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fast_rc_osc_en(fast_en), .slow_rc_osc_en(slow_en),
        .core_clock_en(core_en), .core_run(core_run), .wdt_enable(wdt_en),
        .aux_reset_port_pin_in(aux_in));
    // ------------------------------------------------------------------
    // Clock, timeout and closing report
    // ------------------------------------------------------------------
    always #4 clk = ~clk;
    // The ceiling is far above the longest scenario; a hang ends here.
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_fail++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ------------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------------
    // Setup, access, then hold everything until pready is sampled high.
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask
    // Reset is held for five edges; requests start after the release.
    task automatic rst();
        reset_n <= 1'b0;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
    endtask
    // Spacing between two core clock pulses, measured once steady.
    task automatic pulse_gap(output int g);
        @(posedge clk);
        while (core_en !== 1'b1)
            @(posedge clk);
        g = 0;
        do
        begin
            @(posedge clk);
            g++;
        end
        while (core_en !== 1'b1);
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial
    begin
        clk         = 1'b0;
        reset_n     = 1'b0;
        psel        = 1'b0;
        penable     = 1'b0;
        pwrite      = 1'b0;
        paddr       = 12'h000;
        pwdata      = 32'h00000000;
        pstrb       = 4'hf;
        n_fail      = 0;
        check_count = 0;
        cyc         = 0;
        rst();
        n = 0;
        while (core_run !== 1'b1)
        begin
            @(posedge clk);
            n++;
        end
        chk("boot_delay_ok", 1, n >= SDIV*BOOT && n <= SDIV*BOOT + 6);
        #1;
        chk("osc_after_boot", 2'b01, {fast_en, slow_en});
        chk("wdt_aux", 2'b10, {wdt_en, aux_in});
        xfer(0, RCS_ADDR_CLK_MODE, 0);
        chk("clk_mode_reset", 32'he4, rd);
        xfer(0, RCS_ADDR_TRIM, 0);
        chk("trim_reset", 32'h80, rd);
        xfer(1, RCS_ADDR_TRIM, 32'hffff_ff5a);
        xfer(0, RCS_ADDR_TRIM, 0);
        chk("trim_rw", 32'h5a, rd);
        // An unmapped read answers with an error and zero data.
        xfer(0, 12'h010, 0);
        chk("unmapped_err", 1, err);
        chk("unmapped_data", 0, rd);
        // Fast is always enabled in its own write before being selected,
        // and the old source is only stopped in a later write.
        for (int i = 0; i < 8; i++)
        begin
            xfer(1, RCS_ADDR_CLK_MODE, {24'h0, codes[i]});
            #1;
            chk("osc_enables", {codes[i][4], codes[i][2]}, {fast_en, slow_en});
            xfer(0, RCS_ADDR_CLK_MODE, 0);
            chk("clk_mode", codes[i], rd);
            xfer(0, RCS_ADDR_STATUS, 0);
            chk("status", {28'h0, 2'b01, codes[i][7:5] != 3'h7, 1'b1}, rd);
            pulse_gap(n);
            chk("core_gap", gaps[i], n);
        end
        // The trim directive must be set up while the boot delay runs.
        rst();
        xfer(1, RCS_ADDR_BOOT_CFG, 32'h134);
        while (core_run !== 1'b1)
            @(posedge clk);
        #1;
        chk("trim_boot", 4'b0111, {wdt_en, aux_in, fast_en, slow_en});
        xfer(0, RCS_ADDR_BOOT_CFG, 0);
        chk("boot_cfg", 32'h134, rd);
        xfer(0, RCS_ADDR_CLK_MODE, 0);
        chk("clk_mode_boot", 32'h34, rd);
        pulse_gap(n);
        chk("boot_gap", FDIV*2, n);
        wrap_up();
    end
endmodule
`default_nettype wire
